// ==== hw/active_power_protection_stage.sv ====
// Purpose: one definite-time active power stage (reverse or under power) with AHB-Lite registers
// Assumes: measurement front end and blocking matrix run on hclk
// Notes: logic steps once per 5 ms program cycle
// Functional notes
// [RULE_01] blocking sampled at each program cycle start
// [RULE_02] pick-up without blocking starts delay timing
// [RULE_03] pick-up with blocking gives blocked only
// [RULE_04] late blocking clears start, runs release
// [RULE_05] blocking must arrive 5 ms early
// [RULE_06] definite time only, trip and reset
// [RULE_07] on/off events, selectable for storing
// [RULE_08] events carry time stamp of change
// [RULE_09] resettable counters of start, trip, blocked
// [RULE_10] exactly one independent stage
// [RULE_11] on events logged in twelve-deep ring
// [RULE_12] record holds stamp, name, powers, time, group
// [RULE_13] currents and voltages taken every 5 ms
// [RULE_14] forced status when stage forcing enabled
// [RULE_15] reverse release at 97 percent
// [RULE_16] threshold in 0.01 kW, default 100 kW
// [RULE_17] group settings apply live, no restart
// [RULE_18] signed remaining time in 5 ms steps
// [RULE_19] expected operating time in 5 ms steps
// [RULE_20] live power ratio at 0.01 resolution
// [RULE_21] under release at 103 percent
// [RULE_22] low power inhibit until 1.03 times setting
// [RULE_23] trip after start lasts operate delay
// [RULE_24] status is one of four states
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "power_stage_consts.svh"
module active_power_protection_stage #(
	parameter int CYCLE_CLKS = `APS_CYCLE_NS / `APS_CLK_NS,
	parameter int MS_CLKS = `APS_MS_NS / `APS_CLK_NS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic block_in,
	input wire power_stage_pkg::meas_t meas_in,
	output logic stage_start,
	output logic stage_trip,
	output logic stage_blocked,
	output power_stage_pkg::stage_status_t stage_status,
	output power_stage_pkg::event_t stage_event
);
	// bus
	logic acc;
	logic wr_q, wr_d;
	logic [7:0] wa_q, wa_d;
	logic [31:0] rd_q, rd_d, rd_mux;
	// settings
	logic [8:0] ctrl_q, ctrl_d;
	logic [5:0] evmask_q, evmask_d;
	logic [3:0] recsel_q, recsel_d;
	logic cnt_clr;
	power_stage_pkg::setting_t grp_q [`APS_GROUPS];
	power_stage_pkg::setting_t grp_d [`APS_GROUPS];
	power_stage_pkg::setting_t cur;
	// timebase
	logic [19:0] tcnt_q, tcnt_d;
	logic [16:0] mcnt_q, mcnt_d;
	logic [31:0] ts_q, ts_d;
	logic tick_q, tick_d, eval_q;
	// protection
	logic blk_q, blk_d;
	power_stage_pkg::meas_t meas_q, meas_d;
	logic pick_q, pick_d, inh_q, inh_d, start_q, start_d, trip_q, trip_d, bk_q, bk_d;
	logic [19:0] op_q, op_d, rel_q, rel_d;
	logic [16:0] ratio_q, ratio_d;
	logic signed [19:0] remain_q, remain_d;
	logic signed [47:0] pwr, ps, p100, ratio_full;
	power_stage_pkg::stage_status_t stat_d;
	logic st_o_d, tr_o_d, bk_o_d;
	power_stage_pkg::event_t ev_d;
	logic [5:0] ev_raw;
	logic [15:0] cnt_q [3];
	logic [15:0] cnt_d [3];
	// history and records
	logic signed [31:0] hist [`APS_HIST_DEPTH];
	logic [5:0] hp_q, hp_d, hp_old, hp_pre;
	power_stage_pkg::record_t rec [`APS_REC_DEPTH];
	power_stage_pkg::record_t rec_new, rec_rd;
	logic rec_we;
	logic [3:0] wp_q, wp_d, rcnt_q, rcnt_d;

	assign acc = hsel & hready & htrans[1];
	assign cur = grp_q[ctrl_q[`APS_C_GRP +: 3]];

	// register read mux, driven from the address phase
	always_comb begin
		logic [7:0] a;
		logic [7:0] o;
		a = haddr[7:0];
		o = 8'h00;
		rd_mux = 32'h0000_0000;
		rec_rd = rec[recsel_q];
		if (a == `APS_A_CTRL) begin
			rd_mux = {23'h00_0000, ctrl_q};
		end else if (a == `APS_A_STAT) begin
			rd_mux = {26'h000_0000, blk_q, inh_q, pick_q, 1'b0, stage_status};
		end else if (a == `APS_A_RATIO) begin
			rd_mux = {15'h0000, ratio_q};
		end else if (a == `APS_A_REMAIN) begin
			rd_mux = {{12{remain_q[19]}}, remain_q};
		end else if (a == `APS_A_EXPECT) begin
			rd_mux = {12'h000, cur.op_dly}; // RULE_19
		end else if (a == `APS_A_EVMASK) begin
			rd_mux = {26'h000_0000, evmask_q};
		end else if (a >= `APS_A_CNT && a < `APS_A_TIME) begin
			o = 8'(a - `APS_A_CNT);
			rd_mux = {16'h0000, cnt_q[o[3:2]]};
		end else if (a == `APS_A_TIME) begin
			rd_mux = ts_q;
		end else if (a == `APS_A_RECSEL) begin
			rd_mux = {28'h000_0000, recsel_q};
		end else if (a == `APS_A_RECCNT) begin
			rd_mux = {24'h00_0000, wp_q, rcnt_q};
		end else if (a >= `APS_A_REC && a < `APS_A_GRP) begin
			unique case (a[4:2] ^ 3'h4)
				3'h0: rd_mux = rec_rd.ts_ms;
				3'h1: rd_mux = {30'h0000_0000, rec_rd.code};
				3'h2: rd_mux = rec_rd.pre_trig;
				3'h3: rd_mux = rec_rd.fault;
				3'h4: rd_mux = rec_rd.pre_fault;
				3'h5: rd_mux = {{12{rec_rd.remain[19]}}, rec_rd.remain};
				3'h6: rd_mux = {29'h0000_0000, rec_rd.group};
				default: rd_mux = 32'h0000_0000;
			endcase
		end else if (a >= `APS_A_GRP && a < `APS_A_MEAS) begin
			o = 8'(a - `APS_A_GRP);
			unique case (a[3:2])
				2'h0: rd_mux = grp_q[o[6:4]].pset;
				2'h1: rd_mux = grp_q[o[6:4]].low_power_inhibit;
				2'h2: rd_mux = {12'h000, grp_q[o[6:4]].op_dly};
				2'h3: rd_mux = {12'h000, grp_q[o[6:4]].rel_dly};
			endcase
		end else if (a >= `APS_A_MEAS && a < `APS_A_END) begin
			o = 8'(a - `APS_A_MEAS);
			rd_mux = (o[4:2] < 3'h3) ? {16'h0000, meas_q.current[o[3:2]]} :
				{16'h0000, meas_q.voltage[2'(o[4:2] - 3'h3)]}; // RULE_13
		end
	end

	always_comb begin
		wr_d = acc & hwrite & (hsize == 3'b010);
		wa_d = acc ? haddr[7:0] : wa_q;
		rd_d = (acc & !hwrite) ? rd_mux : rd_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			rd_q <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_q <= wr_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign hrdata = rd_q;

	// settings writes; group table is live, no restart needed
	always_comb begin
		logic [7:0] o;
		o = 8'(wa_q - `APS_A_GRP);
		ctrl_d = ctrl_q;
		evmask_d = evmask_q;
		recsel_d = recsel_q;
		grp_d = grp_q;
		cnt_clr = 1'b0;
		if (wr_q) begin
			if (wa_q == `APS_A_CTRL) begin
				ctrl_d = {1'b0, hwdata[7:0]};
				cnt_clr = hwdata[`APS_C_CLR]; // RULE_09
			end
			if (wa_q == `APS_A_EVMASK) begin
				evmask_d = hwdata[5:0]; // RULE_07
			end
			if (wa_q == `APS_A_RECSEL) begin
				recsel_d = (hwdata[3:0] < 4'(`APS_REC_DEPTH)) ? hwdata[3:0] : recsel_q;
			end
			if (wa_q >= `APS_A_GRP && wa_q < `APS_A_MEAS) begin
				unique case (wa_q[3:2])
					2'h0: grp_d[o[6:4]].pset = hwdata; // RULE_16
					2'h1: grp_d[o[6:4]].low_power_inhibit = hwdata;
					2'h2: grp_d[o[6:4]].op_dly = hwdata[19:0];
					2'h3: grp_d[o[6:4]].rel_dly = hwdata[19:0];
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= 9'h000;
			evmask_q <= 6'h3F;
			recsel_q <= 4'h0;
			for (int g = 0; g < `APS_GROUPS; g++) begin
				grp_q[g] <= {`APS_PSET_RST, `APS_LPB_RST, `APS_OPDLY_RST, `APS_RELDLY_RST}; // RULE_16
			end
		end else begin
			ctrl_q <= ctrl_d;
			evmask_q <= evmask_d;
			recsel_q <= recsel_d;
			grp_q <= grp_d; // RULE_17
		end
	end

	// program cycle tick and millisecond time stamp
	always_comb begin
		tick_d = (tcnt_q == 20'(CYCLE_CLKS - 1));
		tcnt_d = tick_d ? 20'h0_0000 : tcnt_q + 20'h0_0001;
		mcnt_d = (mcnt_q == 17'(MS_CLKS - 1)) ? 17'h0_0000 : mcnt_q + 17'h0_0001;
		ts_d = (mcnt_q == 17'(MS_CLKS - 1)) ? ts_q + 32'h0000_0001 : ts_q;
		if (wr_q && wa_q == `APS_A_TIME) begin
			ts_d = hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tcnt_q <= 20'h0_0000;
			mcnt_q <= 17'h0_0000;
			ts_q <= 32'h0000_0000;
			tick_q <= 1'b0;
			eval_q <= 1'b0;
		end else begin
			tcnt_q <= tcnt_d;
			mcnt_q <= mcnt_d;
			ts_q <= ts_d;
			tick_q <= tick_d;
			eval_q <= tick_q;
		end
	end

	// pick-up, timing, status and events; a single stage
	always_comb begin // RULE_10
		blk_d = tick_q ? block_in : blk_q; // RULE_01
		meas_d = tick_q ? meas_in : meas_q; // RULE_13
		pwr = ctrl_q[`APS_C_REV] ? -48'(meas_q.power) : 48'(meas_q.power);
		ps = 48'(cur.pset);
		p100 = pwr * `APS_PCT_100;
		ratio_full = (ps > 48'sh0000_0000_0000) ? p100 / ps : 48'sh0000_0000_0000;
		if (ratio_full < 48'sh0000_0000_0000) begin
			ratio_full = 48'sh0000_0000_0000;
		end
		if (ratio_full > `APS_RATIO_MAX) begin
			ratio_full = `APS_RATIO_MAX;
		end
		inh_d = ctrl_q[`APS_C_LPB] & (inh_q ? !(p100 > ps * `APS_PCT_UP) : (pwr < 48'(cur.low_power_inhibit))); // RULE_22
		if (ctrl_q[`APS_C_REV]) begin
			pick_d = pick_q ? (p100 > ps * `APS_PCT_DN) : (pwr >= ps); // RULE_15
		end else begin
			pick_d = !inh_d & (pick_q ? (p100 < ps * `APS_PCT_UP) : (pwr < ps)); // RULE_21
		end
		start_d = 1'b0;
		trip_d = 1'b0;
		bk_d = pick_d & blk_q; // RULE_03
		op_d = op_q;
		rel_d = 20'h0_0000;
		// blocking arriving late is honoured even after the delay runs out; start and trip drop and release timing runs
		if (pick_d & !blk_q) begin
			start_d = 1'b1; // RULE_02
			op_d = (op_q >= cur.op_dly) ? op_q : op_q + 20'h0_0001;
			trip_d = (op_d >= cur.op_dly); // RULE_23
		end else if (op_q != 20'h0_0000) begin
			rel_d = rel_q + 20'h0_0001; // RULE_04
			if (rel_d >= cur.rel_dly) begin
				op_d = 20'h0_0000; // RULE_06
				rel_d = 20'h0_0000;
			end
		end
		ratio_d = ratio_full[16:0]; // RULE_20
		remain_d = 20'(cur.op_dly - op_d); // RULE_18
		if (trip_d) begin
			stat_d = power_stage_pkg::ST_TRIP;
		end else if (start_d) begin
			stat_d = power_stage_pkg::ST_START;
		end else if (bk_d) begin
			stat_d = power_stage_pkg::ST_BLOCKED;
		end else begin
			stat_d = power_stage_pkg::ST_NORMAL; // RULE_24
		end
		if (ctrl_q[`APS_C_FEN]) begin
			stat_d = power_stage_pkg::stage_status_t'(ctrl_q[`APS_C_FST +: 2]); // RULE_14
		end
		st_o_d = (stat_d == power_stage_pkg::ST_START) | (stat_d == power_stage_pkg::ST_TRIP);
		tr_o_d = (stat_d == power_stage_pkg::ST_TRIP);
		bk_o_d = (stat_d == power_stage_pkg::ST_BLOCKED);
		ev_raw = {bk_o_d ^ stage_blocked, bk_o_d, tr_o_d ^ stage_trip, tr_o_d,
			st_o_d ^ stage_start, st_o_d};
		ev_raw = ev_raw & {!bk_o_d, 1'b1, !tr_o_d, 1'b1, !st_o_d, 1'b1};
		ev_raw = ev_raw & {stage_blocked | bk_o_d, !stage_blocked, stage_trip | tr_o_d, !stage_trip,
			stage_start | st_o_d, !stage_start};
		ev_raw = eval_q ? ev_raw : 6'h00; // RULE_07
		ev_d.raw = ev_raw;
		ev_d.stored = ev_raw & evmask_q;
		ev_d.ts_ms = ts_q; // RULE_08
		for (int i = 0; i < 3; i++) begin
			cnt_d[i] = cnt_clr ? 16'h0000 : cnt_q[i];
			if (ev_raw[2 * i]) begin
				cnt_d[i] = cnt_d[i] + 16'h0001; // RULE_09
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blk_q <= 1'b0;
			meas_q <= '0;
			pick_q <= 1'b0;
			inh_q <= 1'b1;
			start_q <= 1'b0;
			trip_q <= 1'b0;
			bk_q <= 1'b0;
			op_q <= 20'h0_0000;
			rel_q <= 20'h0_0000;
			ratio_q <= 17'h0_0000;
			remain_q <= 20'sh0_0000;
			stage_status <= power_stage_pkg::ST_NORMAL;
			stage_start <= 1'b0;
			stage_trip <= 1'b0;
			stage_blocked <= 1'b0;
			stage_event <= '0;
			for (int i = 0; i < 3; i++) begin
				cnt_q[i] <= 16'h0000;
			end
		end else begin
			blk_q <= blk_d;
			meas_q <= meas_d;
			stage_event <= ev_d;
			cnt_q <= cnt_d;
			if (eval_q) begin
				pick_q <= pick_d;
				inh_q <= inh_d;
				start_q <= start_d;
				trip_q <= trip_d;
				bk_q <= bk_d;
				op_q <= op_d;
				rel_q <= rel_d;
				ratio_q <= ratio_d;
				remain_q <= remain_d;
				stage_status <= stat_d;
				stage_start <= st_o_d;
				stage_trip <= tr_o_d;
				stage_blocked <= bk_o_d;
			end
		end
	end

	// power history for pre-trigger and pre-fault values, and the record ring
	always_comb begin
		hp_d = eval_q ? ((hp_q == 6'(`APS_HIST_DEPTH - 1)) ? 6'h00 : hp_q + 6'h01) : hp_q;
		hp_old = (hp_q == 6'(`APS_HIST_DEPTH - 1)) ? 6'h00 : hp_q + 6'h01;
		hp_pre = (hp_q >= `APS_PRETRIG_TICKS) ? hp_q - `APS_PRETRIG_TICKS :
			6'(hp_q + 6'(`APS_HIST_DEPTH) - `APS_PRETRIG_TICKS);
		rec_we = ev_raw[0] | ev_raw[2] | ev_raw[4]; // RULE_11
		rec_new.ts_ms = ts_q;
		rec_new.code = ev_raw[2] ? power_stage_pkg::ST_TRIP :
			(ev_raw[0] ? power_stage_pkg::ST_START : power_stage_pkg::ST_BLOCKED);
		rec_new.pre_trig = hist[hp_pre]; // RULE_12
		rec_new.fault = meas_q.power;
		rec_new.pre_fault = hist[hp_old];
		rec_new.remain = remain_d;
		rec_new.group = ctrl_q[`APS_C_GRP +: 3];
		wp_d = rec_we ? ((wp_q == 4'(`APS_REC_DEPTH - 1)) ? 4'h0 : wp_q + 4'h1) : wp_q;
		rcnt_d = (rec_we && rcnt_q != 4'(`APS_REC_DEPTH)) ? rcnt_q + 4'h1 : rcnt_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hp_q <= 6'h00;
			wp_q <= 4'h0;
			rcnt_q <= 4'h0;
		end else begin
			hp_q <= hp_d;
			wp_q <= wp_d;
			rcnt_q <= rcnt_d;
		end
	end

	// storage arrays need no reset; unwritten rec entries are never counted as valid, but unwritten hist entries can be read into records
	always_ff @(posedge hclk) begin
		if (eval_q) begin
			hist[hp_q] <= meas_q.power;
		end
		if (rec_we) begin
			rec[wp_q] <= rec_new; // RULE_11
		end
	end
endmodule

// ==== include/power_stage_consts.svh ====
// Purpose: offsets, field positions, reset values and timing figures of the power stage
// Assumes: 32-bit word registers on an 8-bit byte offset
// Notes: times are in ns; cycle counts are derived in the module
`ifndef POWER_STAGE_CONSTS_SVH
`define POWER_STAGE_CONSTS_SVH
`define APS_CLK_NS 8
`define APS_CYCLE_NS 5000000
`define APS_MS_NS 1000000
`define APS_PCT_100 48'sh0000_0000_0064
`define APS_PCT_UP 48'sh0000_0000_0067
`define APS_PCT_DN 48'sh0000_0000_0061
`define APS_PSET_RST 32'h0000_2710
`define APS_LPB_RST 32'h0000_1388
`define APS_OPDLY_RST 20'h0_0014
`define APS_RELDLY_RST 20'h0_0000
`define APS_RATIO_MAX 48'sh0000_0001_E848
`define APS_HIST_DEPTH 41
`define APS_PRETRIG_TICKS 6'h04
`define APS_REC_DEPTH 12
`define APS_GROUPS 8
`define APS_A_CTRL 8'h00
`define APS_A_STAT 8'h04
`define APS_A_RATIO 8'h08
`define APS_A_REMAIN 8'h0C
`define APS_A_EXPECT 8'h10
`define APS_A_EVMASK 8'h14
`define APS_A_CNT 8'h18
`define APS_A_TIME 8'h24
`define APS_A_RECSEL 8'h28
`define APS_A_RECCNT 8'h2C
`define APS_A_REC 8'h30
`define APS_A_GRP 8'h50
`define APS_A_MEAS 8'hD0
`define APS_A_END 8'hEC
`define APS_C_REV 0
`define APS_C_LPB 1
`define APS_C_FEN 2
`define APS_C_FST 3
`define APS_C_GRP 5
`define APS_C_CLR 8
`endif

// ==== include/power_stage_pkg.sv ====
// Purpose: types shared by the power stage and its bench
// Assumes: power in 0.01 kW units, signed
// Notes: none
package power_stage_pkg;
	typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} stage_status_t;
	typedef struct packed {
		logic signed [31:0] power;
		logic [2:0][15:0] current;
		logic [3:0][15:0] voltage;
	} meas_t;
	typedef struct packed {
		logic signed [31:0] pset;
		logic signed [31:0] low_power_inhibit;
		logic [19:0] op_dly;
		logic [19:0] rel_dly;
	} setting_t;
	typedef struct packed {
		logic [31:0] ts_ms;
		stage_status_t code;
		logic signed [31:0] pre_trig;
		logic signed [31:0] fault;
		logic signed [31:0] pre_fault;
		logic signed [19:0] remain;
		logic [2:0] group;
	} record_t;
	typedef struct packed {
		logic [5:0] raw;
		logic [5:0] stored;
		logic [31:0] ts_ms;
	} event_t;
endpackage

// ==== sim/active_power_protection_stage_assertions.sv ====
// Purpose: port assertions of the active power stage
// Assumes: CYCLE_CLKS equals the instance value
// Notes: bound to the stage top below
`timescale 1ns/1ps
module active_power_protection_stage_assertions #(
	parameter int CYCLE_CLKS = 625000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic stage_start,
	input wire logic stage_trip,
	input wire logic stage_blocked,
	input wire power_stage_pkg::stage_status_t stage_status,
	input wire power_stage_pkg::event_t stage_event
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	power_stage_pkg::stage_status_t prev_q;
	int gap_q;
	// cycles since the last status change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= power_stage_pkg::ST_NORMAL;
			gap_q <= CYCLE_CLKS;
		end else begin
			prev_q <= stage_status;
			gap_q <= (stage_status != prev_q) ? 1 : gap_q + 1;
		end
	end
	ready_ok_a: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	status_gap_a: assert property (stage_status != prev_q |-> gap_q >= CYCLE_CLKS)
		else $error("status changed inside a program cycle");
	start_code_a: assert property (stage_start == (stage_status inside {2'd1, 2'd2}))
		else $error("start output disagrees with status");
	trip_code_a: assert property (stage_trip == (stage_status == 2'd2))
		else $error("trip output disagrees with status");
	blocked_only_a: assert property (stage_blocked |-> !stage_start && stage_status == 2'd3)
		else $error("blocked together with start");
	start_on_a: assert property ($rose(stage_start) |-> ##[0:1] stage_event.raw[0])
		else $error("start on event missing");
	trip_on_a: assert property ($rose(stage_trip) |-> ##[0:1] stage_event.raw[2])
		else $error("trip on event missing");
	block_off_a: assert property ($fell(stage_blocked) |-> ##[0:1] stage_event.raw[5])
		else $error("block off event missing");
	stored_sub_a: assert property ((stage_event.stored & ~stage_event.raw) == 6'h00)
		else $error("stored event without raw event");
	cover property ($rose(stage_trip));
	cover property ($rose(stage_blocked));
	cover property ($fell(stage_blocked) && stage_start);
endmodule
bind active_power_protection_stage active_power_protection_stage_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.stage_start(stage_start),
	.stage_trip(stage_trip),
	.stage_blocked(stage_blocked),
	.stage_status(stage_status),
	.stage_event(stage_event)
);

// ==== sim/active_power_protection_stage_tb_top.sv ====
// Purpose: self-checking bench of the active power stage
// Assumes: program cycle shortened to 50 clocks
// Notes: single word AHB-Lite transfers
`timescale 1ns/1ps
`include "power_stage_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module active_power_protection_stage_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic block_req = 1'b0;
	logic signed [31:0] power_req = 32'sh0000_0000;
	logic block_in;
	power_stage_pkg::meas_t meas_in;
	logic stage_start;
	logic stage_trip;
	logic stage_blocked;
	power_stage_pkg::stage_status_t stage_status;
	power_stage_pkg::event_t stage_event;
	logic [5:0] mask_q = 6'h3F;
	int fail_count = 0;
	int total_checks = 0;
	active_power_protection_stage #(.CYCLE_CLKS(50), .MS_CLKS(10)) dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'b010),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.block_in(block_in),
		.meas_in(meas_in),
		.stage_start(stage_start),
		.stage_trip(stage_trip),
		.stage_blocked(stage_blocked),
		.stage_status(stage_status),
		.stage_event(stage_event)
	);
	power_source_model u_src (
		.hclk(hclk),
		.block_req(block_req),
		.power_req(power_req),
		.block_in(block_in),
		.meas_in(meas_in)
	);
	initial forever #4 hclk = ~hclk;
	always @(posedge hclk)
		if (|stage_event.raw)
			`CHK("stored", stage_event.raw & mask_q, stage_event.stored)
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_st(input logic [1:0] s, output int n);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (stage_status !== s && n < 400);
		if (stage_status !== s) begin
			fail_count++;
			$display("BAD status exp %0h got %0h", s, stage_status);
			tally_and_finish();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		r = hrdata;
		if (k >= 50) begin
			fail_count++;
			$display("BAD hready exp 1 got %0h", hreadyout);
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0000_0000, r);
		`CHK(n, e, r)
	endtask
	task automatic t_trip();
		int n;
		`CHK("status", power_stage_pkg::ST_NORMAL, stage_status)
		rd_chk(`APS_A_GRP, 32'h0000_2710, "pset");
		rd_chk(`APS_A_EXPECT, 32'h0000_0014, "expect");
		rd_chk(`APS_A_EVMASK, 32'h0000_003F, "evmask");
		wr(`APS_A_END, 32'hFFFF_FFFF);
		rd_chk(`APS_A_END, 32'h0000_0000, "unmapped");
		wr(`APS_A_CTRL, 32'h0000_0001);
		wr(8'h58, 32'h0000_0004);
		power_req <= 32'shFFFF_B1E0;
		wait_st(2'd1, n);
		wait_st(2'd2, n);
		`CHK("trip delay", 150, n)
		rd_chk(`APS_A_RATIO, 32'h0000_00C8, "ratio");
		rd_chk(`APS_A_REMAIN, 32'h0000_0000, "remain");
		rd_chk(`APS_A_CNT + 8'h04, 32'h0000_0001, "trips");
		rd_chk(`APS_A_RECCNT, 32'h0000_0022, "reccnt");
		wr(`APS_A_RECSEL, 32'h0000_0001);
		rd_chk(`APS_A_REC + 8'h04, 32'h0000_0002, "rec code");
		rd_chk(`APS_A_REC + 8'h0C, 32'hFFFF_B1E0, "rec fault");
		power_req <= 32'shFFFF_D9B8;
		repeat (120) @(posedge hclk);
		`CHK("held", 1'b1, stage_trip)
		power_req <= 32'shFFFF_DA1C;
		wait_st(2'd0, n);
		$display("done trip");
	endtask
	task automatic t_block();
		int n;
		block_req <= 1'b1;
		power_req <= 32'shFFFF_B1E0;
		wait_st(2'd3, n);
		repeat (100) @(posedge hclk);
		`CHK("no start", 1'b0, stage_start)
		rd_chk(`APS_A_CNT, 32'h0000_0001, "starts");
		block_req <= 1'b0;
		wait_st(2'd1, n);
		block_req <= 1'b1;
		wait_st(2'd3, n);
		`CHK("start cleared", 1'b0, stage_start)
		block_req <= 1'b0;
		power_req <= 32'sh0000_0000;
		wait_st(2'd0, n);
		$display("done block");
	endtask
	task automatic t_force();
		int n;
		wr(`APS_A_EVMASK, 32'h0000_0015);
		mask_q <= 6'h15;
		for (int s = 0; s < 4; s++) begin
			wr(`APS_A_CTRL, 32'h0000_0005 | (s << 3));
			wait_st(s[1:0], n);
		end
		wr(`APS_A_CTRL, 32'h0000_0019);
		wait_st(2'd0, n);
		repeat (120) @(posedge hclk);
		`CHK("unforced", power_stage_pkg::ST_NORMAL, stage_status)
		$display("done force");
	endtask
	task automatic t_under();
		int n;
		power_req <= 32'sh0000_2328;
		wr(`APS_A_CTRL, 32'h0000_0000);
		wait_st(2'd1, n);
		power_req <= 32'sh0000_27D8;
		repeat (120) @(posedge hclk);
		`CHK("under held", 1'b1, stage_start)
		power_req <= 32'sh0000_283C;
		wait_st(2'd0, n);
		wr(`APS_A_GRP, 32'h0000_4E20);
		wait_st(2'd1, n);
		power_req <= 32'sh0000_7530;
		wait_st(2'd0, n);
		wr(`APS_A_CTRL, 32'h0000_0100);
		rd_chk(`APS_A_CNT, 32'h0000_0000, "cleared");
		wr(`APS_A_CTRL, 32'h0000_0002);
		power_req <= 32'sh0000_0FA0;
		repeat (120) @(posedge hclk);
		`CHK("inhibited", power_stage_pkg::ST_NORMAL, stage_status)
		power_req <= 32'sh0000_7530;
		repeat (120) @(posedge hclk);
		power_req <= 32'sh0000_3A98;
		wait_st(2'd1, n);
		$display("done under");
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_trip();
		t_block();
		t_force();
		t_under();
		tally_and_finish();
	end
endmodule

// ==== sim/power_source_model.sv ====
// Purpose: blocking matrix and measurement front end facing the stage
// Assumes: the bench sets the requested values
// Notes: values move one edge after a request
`timescale 1ns/1ps
module power_source_model (
	input wire logic hclk,
	input wire logic block_req,
	input wire logic signed [31:0] power_req,
	output logic block_in,
	output power_stage_pkg::meas_t meas_in
);
	logic blk_q = 1'b0;
	power_stage_pkg::meas_t meas_q = '0;
	always @(posedge hclk) begin
		blk_q <= block_req;
		meas_q.power <= power_req;
		meas_q.current <= {3{power_req[15:0]}};
		meas_q.voltage <= {4{~power_req[15:0]}};
	end
	assign block_in = blk_q;
	assign meas_in = meas_q;
endmodule
